// >>> common/rtrsi_map.vh
/*
 Constants for the tag reply builder: APB register offsets, configuration
 field positions, command codes, tag states, reply field widths.
 Assumes inclusion by bare name from the design file.
*/
`ifndef RTRSI_MAP_VH
`define RTRSI_MAP_VH

`define RTRSI_OFF_CFG 8'h00
`define RTRSI_OFF_SESS_LO 8'h04
`define RTRSI_OFF_SESS_HI 8'h08
`define RTRSI_OFF_UID_LO 8'h0c
`define RTRSI_OFF_UID_HI 8'h10
`define RTRSI_OFF_IDS 8'h14
`define RTRSI_OFF_STATUS 8'h18

`define RTRSI_CFG_RST 32'h0000_ff03
`define RTRSI_CFG_SUP_READ 0
`define RTRSI_CFG_SUP_SYS 1
`define RTRSI_CFG_STORAGE_FORMAT_ID_EN 2
`define RTRSI_CFG_AFI_EN 3
`define RTRSI_CFG_MEMSZ_EN 4
`define RTRSI_CFG_ICREF_EN 5
`define RTRSI_CFG_SENS_LO 6
`define RTRSI_CFG_SENS_HI 7
`define RTRSI_CFG_TYPE_LO 8
`define RTRSI_CFG_TYPE_HI 9
`define RTRSI_CFG_BATT 10
`define RTRSI_CFG_KIND 11
`define RTRSI_CFG_BCNT_LO 12
`define RTRSI_CFG_BCNT_HI 19

`define RTRSI_CMD_READ_BLOCKS 6'h08
`define RTRSI_CMD_SYS_INFO 6'h09

`define RTRSI_ST_READY 3'h0
`define RTRSI_ST_QUIET 3'h1
`define RTRSI_ST_SELECTED 3'h2
`define RTRSI_ST_ROUND_ACTIVE 3'h3
`define RTRSI_ST_ROUND_STANDBY 3'h4

`define RTRSI_ERR_UNSUPPORTED 8'h01
`define RTRSI_ERR_BLOCK_RANGE 8'h10
`define RTRSI_FLAGS_OK 2'h0
`define RTRSI_FLAGS_ERR 2'h2

`define RTRSI_BLK_BITS 32
`define RTRSI_BLK_SIZE_M1 5'h03
`define RTRSI_LEN_FLAGS 8'h02
`define RTRSI_LEN_ERR 8'h0a
`define RTRSI_LEN_SYS_BASE 8'h48
`define RTRSI_LEN_BYTE 8'h08
`define RTRSI_LEN_CAP 8'h20
`define RTRSI_LEN_BLOCK 8'h22
`define RTRSI_LEN_CRC 8'h10
`define RTRSI_SH_BITS 8'h80
`define RTRSI_CRC_INIT 16'hffff
`define RTRSI_CRC_POLY 16'h1021

`endif

// >>> core/rtrsi_reply.v
/*
 Reply builder of a UHF tag for the block-read and system-information
 commands: addressing, silence, error replies, serial reply with CRC-16,
 and an APB register file holding identity and capability settings.
 Assumes a command front end on clk that has checked framing and CRC and
 delivers decoded fields with a one-cycle cmdValid pulse, and a memory that
 answers memAddr combinationally on memData and memSecurity.
*/
`timescale 1ns/100ps
`include "rtrsi_map.vh"

module rtrsi_reply (
   input wire clk,
   input wire rst,
   input wire [7:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire cmdValid,
   input wire [5:0] cmdCode,
   input wire cmdIdFlag,
   input wire [39:0] cmdSessionId,
   input wire [7:0] cmdFirstBlock,
   input wire [7:0] cmdBlockCount,
   input wire cmdError,
   input wire [7:0] cmdErrorCode,
   input wire [2:0] tagState,
   output reg [2:0] nextTagState,
   output reg stateValid,
   output reg [7:0] memAddr,
   input wire [31:0] memData,
   input wire [1:0] memSecurity,
   output reg txBit,
   output reg txValid,
   output reg txDone
);
   localparam PH_IDLE = 2'h0;
   localparam PH_HDR = 2'h1;
   localparam PH_BLK = 2'h2;
   localparam PH_CRC = 2'h3;

   reg [31:0] cfg;
   reg [39:0] sessionTagId;
   reg [63:0] fullTagIdentifier;
   reg [25:0] ids;
   reg [15:0] replyCount;
   reg [1:0] phase;
   reg [127:0] sh;
   reg [7:0] shCnt;
   reg [15:0] crc;
   reg isBlockReply;
   reg [8:0] blkLeft;

   wire [7:0] storageFormatId = ids[7:0];
   wire [7:0] applicationFamilyId = ids[15:8];
   wire [3:0] signature = ids[19:16];
   wire [5:0] chipRef = ids[25:20];
   wire [7:0] blkCntM1 = cfg[`RTRSI_CFG_BCNT_HI:`RTRSI_CFG_BCNT_LO];
   wire apbAcc = psel & penable;
   wire mapped = (paddr == `RTRSI_OFF_CFG) || (paddr == `RTRSI_OFF_SESS_LO) ||
      (paddr == `RTRSI_OFF_SESS_HI) || (paddr == `RTRSI_OFF_UID_LO) ||
      (paddr == `RTRSI_OFF_UID_HI) || (paddr == `RTRSI_OFF_IDS) || (paddr == `RTRSI_OFF_STATUS);
   wire busy = (phase != PH_IDLE);

   assign pready = 1'b1;
   assign pslverr = apbAcc & ~mapped;

   // Config and identity registers; status is read-only
   always @(posedge clk) begin
      if (rst) begin
         cfg <= `RTRSI_CFG_RST;
         sessionTagId <= 40'h00_0000_0000;
         fullTagIdentifier <= 64'h0000_0000_0000_0000;
         ids <= 26'h000_0000;
      end else if (apbAcc && pwrite) begin
         case (paddr)
            `RTRSI_OFF_CFG: cfg <= pwdata;
            `RTRSI_OFF_SESS_LO: sessionTagId[31:0] <= pwdata;
            `RTRSI_OFF_SESS_HI: sessionTagId[39:32] <= pwdata[7:0];
            `RTRSI_OFF_UID_LO: fullTagIdentifier[31:0] <= pwdata;
            `RTRSI_OFF_UID_HI: fullTagIdentifier[63:32] <= pwdata;
            `RTRSI_OFF_IDS: ids <= pwdata[25:0];
            default: ;
         endcase
      end
   end

   always @* begin
      case (paddr)
         `RTRSI_OFF_CFG: prdata = cfg;
         `RTRSI_OFF_SESS_LO: prdata = sessionTagId[31:0];
         `RTRSI_OFF_SESS_HI: prdata = {24'h00_0000, sessionTagId[39:32]};
         `RTRSI_OFF_UID_LO: prdata = fullTagIdentifier[31:0];
         `RTRSI_OFF_UID_HI: prdata = fullTagIdentifier[63:32];
         `RTRSI_OFF_IDS: prdata = {6'h00, ids};
         `RTRSI_OFF_STATUS: prdata = {replyCount, 15'h0000, busy};
         default: prdata = 32'h0000_0000;
      endcase
   end

   // Addressing decision
   wire isRead = (cmdCode == `RTRSI_CMD_READ_BLOCKS);
   wire isSys = (cmdCode == `RTRSI_CMD_SYS_INFO);
   wire idMatch = cmdIdFlag && (cmdSessionId == sessionTagId);
   wire addressed = idMatch || (!cmdIdFlag && tagState == `RTRSI_ST_SELECTED);
   wire supported = isRead ? cfg[`RTRSI_CFG_SUP_READ] : cfg[`RTRSI_CFG_SUP_SYS];
   wire [8:0] lastBlk = {1'b0, cmdFirstBlock} + {1'b0, cmdBlockCount};
   wire rangeBad = isRead && (lastBlk > {1'b0, blkCntM1});
   wire start = cmdValid && !busy && (isRead || isSys) && addressed;

   // Capability word, b1 is bit 0
   wire memSzEn = cfg[`RTRSI_CFG_MEMSZ_EN];
   wire icEn = cfg[`RTRSI_CFG_ICREF_EN];
   wire [15:0] memSize = memSzEn ? {3'h0, `RTRSI_BLK_SIZE_M1, blkCntM1} : 16'h0000;
   wire [31:0] capWord = {memSize,
      (icEn ? chipRef : 6'h00), 2'h0,
      cfg[`RTRSI_CFG_TYPE_HI:`RTRSI_CFG_TYPE_LO],
      cfg[`RTRSI_CFG_SENS_HI:`RTRSI_CFG_SENS_LO],
      icEn, memSzEn, cfg[`RTRSI_CFG_AFI_EN], cfg[`RTRSI_CFG_STORAGE_FORMAT_ID_EN]};

   // Header shift image, left aligned so the first bit leaves from bit 127
   reg [127:0] hdr;
   reg [7:0] hdrLen;
   always @* begin
      hdr = 128'h0;
      hdrLen = `RTRSI_LEN_FLAGS;
      if (!supported) begin
         hdr = {118'h0, `RTRSI_FLAGS_ERR, `RTRSI_ERR_UNSUPPORTED};
         hdrLen = `RTRSI_LEN_ERR;
      end else if (cmdError || rangeBad) begin
         hdr = {118'h0, `RTRSI_FLAGS_ERR, (cmdError ? cmdErrorCode : `RTRSI_ERR_BLOCK_RANGE)};
         hdrLen = `RTRSI_LEN_ERR;
      end else if (isRead) begin
         hdr = {126'h0, `RTRSI_FLAGS_OK};
      end else begin
         hdr = {56'h0, `RTRSI_FLAGS_OK, cfg[`RTRSI_CFG_KIND], cfg[`RTRSI_CFG_BATT], signature,
            fullTagIdentifier};
         hdrLen = `RTRSI_LEN_SYS_BASE;
         if (cfg[`RTRSI_CFG_STORAGE_FORMAT_ID_EN]) begin
            hdr = {hdr[119:0], storageFormatId};
            hdrLen = hdrLen + `RTRSI_LEN_BYTE;
         end
         if (cfg[`RTRSI_CFG_AFI_EN]) begin
            hdr = {hdr[119:0], applicationFamilyId};
            hdrLen = hdrLen + `RTRSI_LEN_BYTE;
         end
         hdr = {hdr[95:0], capWord};
         hdrLen = hdrLen + `RTRSI_LEN_CAP;
      end
      hdr = hdr << (`RTRSI_SH_BITS - hdrLen);
   end

   wire fb = sh[127] ^ crc[15];
   wire [15:0] next_crc = {crc[14:0], 1'b0} ^ (fb ? `RTRSI_CRC_POLY : 16'h0000);
   wire lastBit = (shCnt == 8'h01);

   always @(posedge clk) begin
      if (rst) begin
         phase <= PH_IDLE;
         sh <= 128'h0;
         shCnt <= 8'h00;
         crc <= `RTRSI_CRC_INIT;
         isBlockReply <= 1'b0;
         blkLeft <= 9'h000;
         memAddr <= 8'h00;
         txBit <= 1'b0;
         txValid <= 1'b0;
         txDone <= 1'b0;
         nextTagState <= `RTRSI_ST_READY;
         stateValid <= 1'b0;
         replyCount <= 16'h0000;
      end else begin
         txDone <= 1'b0;
         stateValid <= 1'b0;
         if (cmdValid && (isRead || isSys) && !busy) begin
            nextTagState <= tagState;
            stateValid <= 1'b1;
         end
         case (phase)
            PH_IDLE: begin
               txValid <= 1'b0;
               if (start) begin
                  phase <= PH_HDR;
                  sh <= hdr;
                  shCnt <= hdrLen;
                  crc <= `RTRSI_CRC_INIT;
                  isBlockReply <= isRead && supported && !cmdError && !rangeBad;
                  blkLeft <= {1'b0, cmdBlockCount} + 9'h001;
                  memAddr <= cmdFirstBlock;
                  replyCount <= replyCount + 16'h0001;
               end
            end
            PH_HDR, PH_BLK: begin
               txBit <= sh[127];
               txValid <= 1'b1;
               crc <= next_crc;
               sh <= {sh[126:0], 1'b0};
               shCnt <= shCnt - 8'h01;
               if (lastBit) begin
                  if (isBlockReply && blkLeft != 9'h000) begin
                     // Memory is read on the last bit of the segment before its own serial slot
                     phase <= PH_BLK;
                     sh <= {memSecurity, memData, 94'h0};
                     shCnt <= `RTRSI_LEN_BLOCK;
                     blkLeft <= blkLeft - 9'h001;
                     memAddr <= memAddr + 8'h01;
                  end else begin
                     phase <= PH_CRC;
                     sh <= {next_crc, 112'h0};
                     shCnt <= `RTRSI_LEN_CRC;
                  end
               end
            end
            PH_CRC: begin
               txBit <= sh[127];
               txValid <= 1'b1;
               sh <= {sh[126:0], 1'b0};
               shCnt <= shCnt - 8'h01;
               if (lastBit) begin
                  phase <= PH_IDLE;
                  txDone <= 1'b1;
               end
            end
            default: phase <= PH_IDLE;
         endcase
      end
   end
endmodule // rtrsi_reply

// >>> bench/rtrsi_reply_asserts.sv
/*
 Assertions on the reply builder ports.
 Assumes a bind to rtrsi_reply from the testbench top file.
*/
`timescale 1ns/100ps
module rtrsi_reply_asserts (
   input wire clk,
   input wire rst,
   input wire cmdValid,
   input wire cmdIdFlag,
   input wire [7:0] cmdFirstBlock,
   input wire [2:0] tagState,
   input wire [2:0] nextTagState,
   input wire stateValid,
   input wire [7:0] memAddr,
   input wire txValid,
   input wire txDone
);
   reg [15:0] bitCnt;
   // Counts earlier bits of the reply, so the shortest reply can be bounded
   always @(posedge clk) begin
      if (rst || !txValid)
         bitCnt <= 16'h0;
      else
         bitCnt <= bitCnt + 16'h1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   state_kept_a: assert property (stateValid |-> nextTagState == $past(tagState))
      else $error("tag state altered");
   // Only a reply that really started loads the first block; silent commands leave memAddr alone
   first_block_a: assert property (stateValid ##1 txValid |-> memAddr == $past(cmdFirstBlock, 2))
      else $error("wrong first block");
   taken_cause_a: assert property (stateValid |-> $past(cmdValid) && !$past(txValid))
      else $error("reply without command");
   // A selected tag must answer a command without identifier
   reply_start_a: assert property (stateValid && $past(cmdIdFlag) == 1'b0 && $past(tagState) == 3'h2
      |=> txValid && !$past(txValid)) else $error("reply late");
   unaddr_quiet_a: assert property (cmdValid && !cmdIdFlag && tagState != 3'h2 && !txValid && !stateValid
      |-> ##2 !txValid) else $error("unselected tag replied");
   reply_run_a: assert property (txValid && !txDone |=> txValid)
      else $error("reply broken");
   done_last_a: assert property (txDone |-> txValid ##1 !txValid)
      else $error("done not on last bit");
   min_len_a: assert property (txDone |-> bitCnt >= 16'h19)
      else $error("reply too short");
   reply_bound_a: assert property ($rose(txValid) |-> ##[25:200] txDone)
      else $error("reply never ended");
   cover property (stateValid && tagState != 3'h2);
   cover property (txDone);
   cover property (cmdValid && cmdIdFlag && tagState == 3'h2);
endmodule // rtrsi_reply_asserts

// >>> bench/rtrsi_far_model.sv
/*
 Far side: block memory and reply bit collector.
 Assumes memAddr is answered combinationally, one bit per txValid cycle.
*/
`timescale 1ns/100ps
module rtrsi_far_model (
   input wire clk,
   input wire [7:0] memAddr,
   input wire stateValid,
   input wire txValid,
   input wire txBit,
   output wire [31:0] memData,
   output wire [1:0] memSecurity,
   output reg [511:0] rxBits,
   output reg [15:0] rxLen
);
   // Contents differ per block so a wrong order shows
   assign memData = {4{memAddr ^ 8'h5a}};
   assign memSecurity = memAddr[1:0];
   always @(posedge clk) begin
      if (stateValid) begin
         rxBits <= 512'h0;
         rxLen <= 16'h0;
      end else if (txValid) begin
         rxBits <= {rxBits[510:0], txBit};
         rxLen <= rxLen + 16'h1;
      end
   end
endmodule // rtrsi_far_model

// >>> bench/rtrsi_testbench.sv
/*
 Testbench: APB setup, commands, bit-exact reply checks.
 Assumes the far model and checker are compiled first.
*/
`timescale 1ns/100ps
module testbench;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cmdValid = 1'b0, cmdIdFlag = 1'b0;
   logic cmdError = 1'b0, pready, pslverr, stateValid, txBit, txValid, txDone, seen, rerr;
   logic [7:0] paddr = 8'h0, cmdFirstBlock = 8'h0, cmdBlockCount = 8'h0, cmdErrorCode = 8'h2a, memAddr;
   logic [31:0] pwdata = 32'h0, prdata, rdata, memData;
   logic [5:0] cmdCode = 6'h0;
   logic [39:0] cmdSessionId = 40'h0, sid = 40'h12_89ab_cdef;
   logic [2:0] tagState = 3'h0, nextTagState;
   logic [1:0] memSecurity;
   logic [511:0] rxBits, exp;
   logic [15:0] rxLen, expLen;
   integer miscompares = 0, numChecks = 0;
   rtrsi_reply i_dut (.clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .cmdValid,
      .cmdCode, .cmdIdFlag, .cmdSessionId, .cmdFirstBlock, .cmdBlockCount, .cmdError, .cmdErrorCode, .tagState,
      .nextTagState, .stateValid, .memAddr, .memData, .memSecurity, .txBit, .txValid, .txDone);
   rtrsi_far_model i_far (.clk, .memAddr, .stateValid, .txValid, .txBit, .memData, .memSecurity, .rxBits, .rxLen);
   initial begin
      forever #5 clk = ~clk;
   end
   task chk(input logic [511:0] g, input logic [511:0] e);
      numChecks++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected at %0t: got %0h want %0h", $time, g, e);
      end
   endtask
   task finalReport;
      $display("checks %0d miscompares %0d", numChecks, miscompares);
      if (miscompares == 0 && numChecks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task cmd(input logic [5:0] c, input logic f, input logic [39:0] id, input logic [7:0] fb, input logic [7:0] bc,
      input logic [2:0] st, input logic e);
      @(posedge clk);
      cmdValid <= 1'b1;
      cmdCode <= c;
      cmdIdFlag <= f;
      cmdSessionId <= id;
      cmdFirstBlock <= fb;
      cmdBlockCount <= bc;
      tagState <= st;
      cmdError <= e;
      @(posedge clk);
      cmdValid <= 1'b0;
      seen = 1'b0;
      for (int n = 0; n < 200 && !seen; n++) begin
         @(posedge clk);
         seen = txDone === 1'b1;
      end
      @(posedge clk);
   endtask
   task put(input logic [63:0] v, input integer w);
      for (int i = w - 1; i >= 0; i--) begin
         exp = {exp[510:0], v[i]};
         expLen++;
      end
   endtask
   task start(input logic [1:0] f);
      exp = '0;
      expLen = 16'h0;
      put(f, 2);
   endtask
   task blk(input logic [7:0] fb, input logic [7:0] bc);
      for (logic [8:0] a = fb; a <= fb + bc; a++) begin
         put(a[1:0], 2);
         put({4{a[7:0] ^ 8'h5a}}, 32);
      end
   endtask
   // Reference CRC is bitwise, in the same serial shift form as the design's
   task checkReply;
      logic [15:0] c;
      c = 16'hffff;
      for (int i = expLen - 1; i >= 0; i--)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ exp[i]) ? 16'h1021 : 16'h0000);
      put(c, 16);
      chk(rxBits, exp);
      chk(rxLen, expLen);
   endtask
   task errReply(input logic [7:0] code);
      start(2'h2);
      put(code, 8);
      checkReply;
   endtask
   task info(input logic [31:0] cap, input logic opt);
      start(2'h0);
      put(6'h39, 6);
      put(64'h89ab_cdef_0123_4567, 64);
      if (opt)
         put(16'h5ec3, 16);
      put(cap, 32);
      checkReply;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, 8'h00, 32'h0);
      chk(rdata, 32'h0000_ff03);
      apb(1'b0, 8'h1c, 32'h0);
      chk({rerr, rdata}, 33'h1_0000_0000);
      apb(1'b1, 8'h04, 32'h89ab_cdef);
      apb(1'b1, 8'h08, 32'h0000_0012);
      apb(1'b1, 8'h0c, 32'h0123_4567);
      apb(1'b1, 8'h10, 32'h89ab_cdef);
      apb(1'b1, 8'h14, 32'h0159_c35e);
      apb(1'b1, 8'h00, 32'h0000_fdbf);
      cmd(6'h08, 1'b0, 40'h0, 8'h03, 8'h01, 3'h2, 1'b0);
      start(2'h0);
      blk(8'h03, 8'h01);
      checkReply;
      for (int s = 0; s < 5; s++) begin
         cmd(6'h08, 1'b1, sid, 8'h0f, 8'h00, s[2:0], 1'b0);
         start(2'h0);
         blk(8'h0f, 8'h00);
         checkReply;
         chk(nextTagState, s[2:0]);
      end
      cmd(6'h08, 1'b1, sid ^ 40'h1, 8'h0, 8'h0, 3'h2, 1'b0);
      chk(seen, 1'b0);
      cmd(6'h09, 1'b0, sid, 8'h0, 8'h0, 3'h3, 1'b0);
      chk(seen, 1'b0);
      cmd(6'h09, 1'b1, sid ^ 40'h80_0000_0000, 8'h0, 8'h0, 3'h0, 1'b0);
      chk(seen, 1'b0);
      cmd(6'h09, 1'b1, sid, 8'h0, 8'h0, 3'h4, 1'b0);
      info(32'h030f_546f, 1'b1);
      apb(1'b1, 8'h00, 32'h0000_fd83);
      cmd(6'h09, 1'b0, 40'h0, 8'h0, 8'h0, 3'h2, 1'b0);
      info(32'h0000_0060, 1'b0);
      apb(1'b1, 8'h00, 32'h0000_fd80);
      for (int k = 8; k < 10; k++) begin
         cmd(k[5:0], 1'b0, 40'h0, 8'h0, 8'h0, 3'h2, 1'b0);
         errReply(8'h01);
      end
      apb(1'b1, 8'h00, 32'h0000_fd83);
      cmd(6'h08, 1'b0, 40'h0, 8'h0, 8'h0, 3'h2, 1'b1);
      errReply(8'h2a);
      cmd(6'h08, 1'b0, 40'h0, 8'h0f, 8'h01, 3'h2, 1'b0);
      errReply(8'h10);
      // Twelve replies were started, none is running now
      apb(1'b0, 8'h18, 32'h0);
      chk({rerr, rdata}, 33'h0_000c_0000);
      finalReport;
   end
   initial begin
      #200000;
      miscompares++;
      finalReport;
   end
endmodule // testbench
bind rtrsi_reply rtrsi_reply_asserts i_chk (.clk, .rst, .cmdValid, .cmdIdFlag, .cmdFirstBlock, .tagState,
   .nextTagState, .stateValid, .memAddr, .txValid, .txDone);
